/* File: fmc_pkg.sv */
package fmc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 250_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int MIN_RATE_HZ   = 22_500;
  localparam int MAX_RATE_HZ   = 51_500;
  localparam int BURST_HZ      = 885;
  // Period of a rate: longest time, rounds down
  localparam int MIN_RATE_CYC  = CLK_HZ / MIN_RATE_HZ;
  localparam int MAX_RATE_CYC  = CLK_HZ / MAX_RATE_HZ;
  localparam int BURST_CYC     = CLK_HZ / BURST_HZ;
  // Guard on stroke length: longest time, rounds down
  localparam int MAX_ON_NS     = 15_000;
  localparam int MAX_ON_CYC    = (MAX_ON_NS * CLK_MHZ) / 1000;
  // Wait from stroke end to feedback sample: least time, rounds up
  localparam int SAMPLE_DLY_NS = 2_000;
  localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Widths and levels
  // ----------------------------------------------------------------
  localparam int PER_W   = 16;
  localparam int BURST_W = 20;
  localparam int PK_W    = 10;
  localparam int CNT_W   = 12;
  localparam int SCNT_W  = 8;
  localparam int SENSE_W = 6;

  // Peak-current target in mV across the sense resistor
  localparam logic [PK_W-1:0]   PK_MIN_MV  = 10'h078;
  localparam logic [PK_W-1:0]   PK_MAX_MV  = 10'h235;
  localparam logic [PK_W-1:0]   PK_STEP_MV = 10'h005;
  localparam logic [PER_W-1:0]  PER_STEP   = 16'h0010;
  localparam logic [SCNT_W-1:0] SCNT_MAX   = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STARTUP,
    MODE_VOLTAGE_BURST,
    MODE_VOLTAGE_PEAK_CURRENT,
    MODE_VOLTAGE_FREQUENCY,
    MODE_CURRENT_FREQUENCY,
    MODE_CURRENT_PEAK_CURRENT
  } fmc_mode_t;

  // Comparator results from the analogue front end
  typedef struct packed {
    logic fb_low;      // feedback_sense below 2.5 V
    logic fb_rel_low;  // feedback_sense below burst_release_threshold
    logic pk_hit;      // primary current reached peak target
    logic iout_over;   // output current above output_current_limit
    logic vcc_stop;    // supply below 8.5 V stop level
    logic vcc_start;   // supply at or above 17 V start level
  } fmc_sense_t;

endpackage

/* File: fmc_sync.sv */
`timescale 1ns/1ns
module fmc_sync
  import fmc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,  // Core clock
  input  wire logic         rst,      // Async reset
  input  wire logic [W-1:0] d_in,     // Asynchronous levels
  output logic      [W-1:0] q_out     // Synchronised levels
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= d_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign q_out = sync_ff;

endmodule // fmc_sync

/* File: fmc_ticker.sv */
`timescale 1ns/1ns
module fmc_ticker
  import fmc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,  // Core clock
  input  wire logic         rst,      // Async reset
  input  wire logic         restart,  // Restart the interval
  input  wire logic [W-1:0] len,      // Interval in cycles
  output logic              tick      // One-cycle pulse per interval
);

  logic [W-1:0] cnt_ff;
  logic         tick_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= len - 1'b1) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule // fmc_ticker

/* File: fmc_top.sv */
`timescale 1ns/1ns
// What this block does
// - Burst period opens at fixed interval, one minimum stroke
// - Sample high after stroke: energy-save until next burst
// - Sample low: keep stroking until sample rises
// - Feedback below 2.4 V: jump to voltage peak-current
// - Burst strokes at 22.5 kHz, minimum peak
// - Burst period filled: move to voltage peak-current
// - Stroke count per burst varies, average regulated
// - Voltage peak-current: continuous at 22.5 kHz from minimum peak, from maximum when entered from voltage frequency
// - Voltage peak-current: fixed rate, raise peak target
// - Peak target at maximum: go voltage frequency
// - Voltage frequency: maximum peak, rate up to 51.5 kHz
// - Demand beyond maximum power: go current frequency
// - Current frequency: maximum peak, rate holds current limit
// - Rate at minimum: go current peak-current
// - Current peak-current: minimum rate, peak target lowered
// - Supply below stop level: stop, restart, hiccup
// - Stop level 8.5 V re-enables start-up source
// - Switching starts only at 17 V start level
module fmc_top
  import fmc_pkg::*;
#(
  parameter int BURST_PERIOD  = BURST_CYC,
  parameter int MIN_RATE_PER  = MIN_RATE_CYC,
  parameter int MAX_RATE_PER  = MAX_RATE_CYC
) (
  input  wire logic              ref_clk,         // Core clock, 250 MHz
  input  wire logic              rst,             // Async reset
  input  wire fmc_sense_t        sense_raw,       // Comparator levels
  output logic                   switch_on,       // Power switch gate
  output logic [PK_W-1:0]        peak_target,     // Peak target, mV
  output logic [PER_W-1:0]       period_len,      // Stroke period, cycles
  output fmc_mode_t              mode,            // Control mode
  output logic                   energy_save,     // Idle until next burst
  output logic                   startup_src_on,  // Start-up source enable
  output logic [SCNT_W-1:0]      burst_strokes    // Strokes last burst
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam logic [PER_W-1:0]   MIN_P   = PER_W'(MIN_RATE_PER);
  localparam logic [PER_W-1:0]   MAX_P   = PER_W'(MAX_RATE_PER);
  localparam logic [BURST_W-1:0] BURST_P = BURST_W'(BURST_PERIOD);
  localparam logic [CNT_W-1:0]   ON_LAST = CNT_W'(MAX_ON_CYC - 1);
  localparam logic [CNT_W-1:0]   SMP_LAST = CNT_W'(SAMPLE_DLY_CYC - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fmc_sense_t          sense_s;
  fmc_mode_t           state_ff;
  fmc_mode_t           nxt_state;
  logic                stroke_ff;
  logic                wait_ff;
  logic [CNT_W-1:0]    phase_cnt_ff;
  logic [PK_W-1:0]     target_ff;
  logic [PER_W-1:0]    period_ff;
  logic                save_ff;
  logic                src_ff;
  logic [SCNT_W-1:0]   scnt_ff;
  logic [SCNT_W-1:0]   last_scnt_ff;
  logic                stroke_tick;
  logic                burst_tick;
  logic                in_burst;
  logic                running;
  logic                burst_start;
  logic                start_stroke;
  logic                end_stroke;
  logic                sample_now;
  logic                stroke_restart;
  logic [PK_W-1:0]     pk_up;
  logic [PK_W-1:0]     pk_dn;
  logic [PER_W-1:0]    per_up;
  logic [PER_W-1:0]    per_dn;

  // ----------------------------------------------------------------
  // Input synchronisers and interval counters
  // ----------------------------------------------------------------
  fmc_sync #(
    .W       (SENSE_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d_in    (sense_raw),
    .q_out   (sense_s)
  );

  // Restarted at each burst so the stroke train lines up with it
  assign stroke_restart = burst_start || (state_ff == MODE_STARTUP);

  fmc_ticker #(
    .W       (PER_W)
  ) u_stroke_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (stroke_restart),
    .len     (period_ff),
    .tick    (stroke_tick)
  );

  fmc_ticker #(
    .W       (BURST_W)
  ) u_burst_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (!in_burst),
    .len     (BURST_P),
    .tick    (burst_tick)
  );

  // ----------------------------------------------------------------
  // Step helpers, clamped to the documented range
  // ----------------------------------------------------------------
  assign pk_up  = (target_ff >= PK_MAX_MV - PK_STEP_MV) ? PK_MAX_MV
                                                        : target_ff + PK_STEP_MV;
  assign pk_dn  = (target_ff <= PK_MIN_MV + PK_STEP_MV) ? PK_MIN_MV
                                                        : target_ff - PK_STEP_MV;
  assign per_up = (period_ff + PER_STEP >= MIN_P) ? MIN_P
                                                  : period_ff + PER_STEP;
  assign per_dn = (period_ff <= MAX_P + PER_STEP) ? MAX_P
                                                  : period_ff - PER_STEP;

  // ----------------------------------------------------------------
  // Stroke sequencing
  // ----------------------------------------------------------------
  assign in_burst    = (state_ff == MODE_VOLTAGE_BURST);
  assign running     = (state_ff != MODE_STARTUP) && !sense_s.vcc_stop;
  assign burst_start = in_burst && burst_tick;
  // New stroke only when the previous stroke and its sample are done
  assign start_stroke = running && !stroke_ff && !wait_ff &&
                        (burst_start || (stroke_tick && !save_ff));
  assign end_stroke  = stroke_ff &&
                       (sense_s.pk_hit || phase_cnt_ff == ON_LAST);
  assign sample_now  = wait_ff && (phase_cnt_ff == SMP_LAST);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stroke_ff    <= 1'b0;
      wait_ff      <= 1'b0;
      phase_cnt_ff <= '0;
    end else if (!running) begin
      stroke_ff    <= 1'b0;
      wait_ff      <= 1'b0;
      phase_cnt_ff <= '0;
    end else if (start_stroke) begin
      stroke_ff    <= 1'b1;
      wait_ff      <= 1'b0;
      phase_cnt_ff <= '0;
    end else if (end_stroke) begin
      // Sample late in the secondary stroke, away from diode drop
      stroke_ff    <= 1'b0;
      wait_ff      <= 1'b1;
      phase_cnt_ff <= '0;
    end else if (sample_now) begin
      wait_ff      <= 1'b0;
      phase_cnt_ff <= '0;
    end else if (stroke_ff || wait_ff) begin
      phase_cnt_ff <= phase_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Energy save between bursts
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      save_ff <= 1'b0;
    end else if (!in_burst || burst_start) begin
      save_ff <= 1'b0;
    end else if (sample_now && !sense_s.fb_low) begin
      save_ff <= 1'b1;
    end
  end

  // Strokes in each burst; the loop regulates their average only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scnt_ff      <= '0;
      last_scnt_ff <= '0;
    end else if (burst_start) begin
      last_scnt_ff <= scnt_ff;
      scnt_ff      <= SCNT_W'(1);
    end else if (start_stroke && in_burst && scnt_ff != SCNT_MAX) begin
      scnt_ff      <= scnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MODE_STARTUP: begin
        if (sense_s.vcc_start && !sense_s.vcc_stop) begin
          nxt_state = MODE_VOLTAGE_BURST;
        end
      end
      MODE_VOLTAGE_BURST: begin
        if (sense_s.fb_rel_low) begin
          nxt_state = MODE_VOLTAGE_PEAK_CURRENT;
        end else if (burst_tick && !save_ff) begin
          nxt_state = MODE_VOLTAGE_PEAK_CURRENT;
        end
      end
      MODE_VOLTAGE_PEAK_CURRENT: begin
        if (sample_now && sense_s.fb_low && pk_up == PK_MAX_MV) begin
          nxt_state = MODE_VOLTAGE_FREQUENCY;
        end else if (sample_now && !sense_s.fb_low &&
                     target_ff == PK_MIN_MV) begin
          nxt_state = MODE_VOLTAGE_BURST;
        end
      end
      MODE_VOLTAGE_FREQUENCY: begin
        if (sample_now && sense_s.fb_low && per_dn == MAX_P) begin
          nxt_state = MODE_CURRENT_FREQUENCY;
        end else if (sample_now && !sense_s.fb_low && per_up == MIN_P) begin
          nxt_state = MODE_VOLTAGE_PEAK_CURRENT;
        end
      end
      MODE_CURRENT_FREQUENCY: begin
        if (sample_now && sense_s.iout_over && per_up == MIN_P) begin
          nxt_state = MODE_CURRENT_PEAK_CURRENT;
        end else if (sample_now && !sense_s.iout_over &&
                     !sense_s.fb_low) begin
          nxt_state = MODE_VOLTAGE_FREQUENCY;
        end
      end
      MODE_CURRENT_PEAK_CURRENT: begin
        if (sample_now && !sense_s.iout_over && pk_up == PK_MAX_MV) begin
          nxt_state = MODE_CURRENT_FREQUENCY;
        end
      end
      default: begin
        nxt_state = MODE_STARTUP;
      end
    endcase
    if (state_ff != MODE_STARTUP && sense_s.vcc_stop) begin
      nxt_state = MODE_STARTUP;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= MODE_STARTUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Peak-current target
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      target_ff <= PK_MIN_MV;
    end else begin
      case (nxt_state)
        MODE_VOLTAGE_PEAK_CURRENT: begin
          if (state_ff != MODE_VOLTAGE_PEAK_CURRENT) begin
            target_ff <= (state_ff == MODE_VOLTAGE_FREQUENCY) ?
                         PK_MAX_MV : PK_MIN_MV;
          end else if (sample_now) begin
            target_ff <= sense_s.fb_low ? pk_up : pk_dn;
          end
        end
        MODE_VOLTAGE_FREQUENCY, MODE_CURRENT_FREQUENCY: begin
          target_ff <= PK_MAX_MV;
        end
        MODE_CURRENT_PEAK_CURRENT: begin
          if (state_ff == MODE_CURRENT_PEAK_CURRENT && sample_now) begin
            target_ff <= sense_s.iout_over ? pk_dn : pk_up;
          end else if (state_ff != MODE_CURRENT_PEAK_CURRENT) begin
            target_ff <= PK_MAX_MV;
          end
        end
        default: begin
          // Burst and start-up use the minimum peak only
          target_ff <= PK_MIN_MV;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Switching period
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_ff <= MIN_P;
    end else begin
      case (nxt_state)
        MODE_VOLTAGE_FREQUENCY: begin
          if (state_ff == MODE_VOLTAGE_FREQUENCY && sample_now) begin
            period_ff <= sense_s.fb_low ? per_dn : per_up;
          end
        end
        MODE_CURRENT_FREQUENCY: begin
          if (state_ff == MODE_CURRENT_FREQUENCY && sample_now) begin
            period_ff <= sense_s.iout_over ? per_up : per_dn;
          end else if (state_ff == MODE_VOLTAGE_FREQUENCY) begin
            // Left on the last step, so land on the rate ceiling
            period_ff <= MAX_P;
          end else if (state_ff != MODE_CURRENT_FREQUENCY) begin
            period_ff <= MIN_P;
          end
        end
        default: begin
          period_ff <= MIN_P;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start-up source
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_ff <= 1'b1;
    end else begin
      src_ff <= (nxt_state == MODE_STARTUP);
    end
  end

  assign switch_on      = stroke_ff;
  assign peak_target    = target_ff;
  assign period_len     = period_ff;
  assign mode           = state_ff;
  assign energy_save    = save_ff;
  assign startup_src_on = src_ff;
  assign burst_strokes  = last_scnt_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_enter_vfreq;
    state_ff == MODE_VOLTAGE_PEAK_CURRENT ##1
    state_ff == MODE_VOLTAGE_FREQUENCY;
  endsequence

  sequence s_enter_cpeak;
    state_ff == MODE_CURRENT_FREQUENCY ##1
    state_ff == MODE_CURRENT_PEAK_CURRENT;
  endsequence

  a_uvlo_stop: assert property (
    (state_ff != MODE_STARTUP && sense_s.vcc_stop) |=>
      (state_ff == MODE_STARTUP && !stroke_ff && src_ff))
    else $error("supply stop did not halt switching");

  a_startup_hold: assert property (
    (state_ff == MODE_STARTUP) |-> (!stroke_ff && !wait_ff))
    else $error("switching during start-up");

  a_source_off: assert property (
    (state_ff != MODE_STARTUP) |-> !src_ff)
    else $error("start-up source on while running");

  a_burst_min_pk: assert property (
    (state_ff == MODE_VOLTAGE_BURST) |-> (target_ff == PK_MIN_MV))
    else $error("burst stroke above minimum peak");

  a_release_jump: assert property (
    (in_burst && sense_s.fb_rel_low && !sense_s.vcc_stop) |=>
      (state_ff == MODE_VOLTAGE_PEAK_CURRENT))
    else $error("release threshold did not leave burst");

  a_save_enter: assert property (
    (in_burst && sample_now && !sense_s.fb_low &&
     !sense_s.fb_rel_low && !sense_s.vcc_stop && !burst_tick) |=>
      (save_ff && !stroke_ff) ##1 !stroke_ff)
    else $error("energy save not entered after high sample");

  a_vpeak_rate: assert property (
    (state_ff == MODE_VOLTAGE_PEAK_CURRENT) |-> (period_ff == MIN_P))
    else $error("rate not minimum in voltage peak-current");

  a_vfreq_entry: assert property (
    s_enter_vfreq |-> (target_ff == PK_MAX_MV))
    else $error("voltage frequency entered below maximum peak");

  a_freq_pk_max: assert property (
    (state_ff == MODE_VOLTAGE_FREQUENCY ||
     state_ff == MODE_CURRENT_FREQUENCY) |->
      (target_ff == PK_MAX_MV && period_ff >= MAX_P))
    else $error("frequency mode off maximum peak or rate");

  a_cpeak_entry: assert property (
    s_enter_cpeak |-> (period_ff == MIN_P))
    else $error("current peak-current entered off minimum rate");

  a_stroke_end: assert property (
    (stroke_ff && sense_s.pk_hit && running) |=>
      (!stroke_ff && wait_ff) [*2])
    else $error("stroke did not end on peak hit");

endmodule // fmc_top

/* File: fmc_flyback_model.sv */
`timescale 1ns/1ns
module fmc_flyback_model
  import fmc_pkg::*;
(
  input  wire logic       ref_clk,    // Core clock
  input  wire logic       switch_on,  // Gate from controller
  input  wire logic [7:0] pk_dly,     // Cycles until peak is reached
  input  wire fmc_sense_t load_lvl,   // Levels set by the bench
  output fmc_sense_t      sense_raw   // Comparator levels
);
  logic [7:0] ramp_ff;

  // Primary current ramps only while the switch conducts
  always_ff @(posedge ref_clk) begin
    if (!switch_on) begin
      ramp_ff <= 8'h00;
    end else if (ramp_ff != 8'hff) begin
      ramp_ff <= ramp_ff + 8'h01;
    end
  end

  // Peak comparator drops at once when the switch opens
  always_comb begin
    sense_raw        = load_lvl;
    sense_raw.pk_hit = switch_on && (ramp_ff >= pk_dly);
  end
endmodule // fmc_flyback_model

/* File: fmc_top_bench.sv */
`timescale 1ns/1ns
module fmc_top_bench
  import fmc_pkg::*;
;
  // Stroke plus sample wait must fit inside the shortest period
  localparam int BP   = 2000;
  localparam int MINP = 660;
  localparam int MAXP = 600;

  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  fmc_sense_t        load_lvl = '0;
  fmc_sense_t        sense_raw;
  logic              switch_on;
  logic              energy_save;
  logic              startup_src_on;
  logic [PK_W-1:0]   peak_target;
  logic [PER_W-1:0]  period_len;
  fmc_mode_t         mode;
  logic [SCNT_W-1:0] burst_strokes;
  logic              prev_sw;
  int                error_cnt = 0;
  int                checks_done = 0;
  int                strokes;
  int                waited;

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  fmc_top #(.BURST_PERIOD(BP), .MIN_RATE_PER(MINP), .MAX_RATE_PER(MAXP))
  uut (
    .ref_clk(ref_clk), .rst(rst), .sense_raw(sense_raw),
    .switch_on(switch_on), .peak_target(peak_target),
    .period_len(period_len), .mode(mode), .energy_save(energy_save),
    .startup_src_on(startup_src_on), .burst_strokes(burst_strokes)
  );

  fmc_flyback_model plant (
    .ref_clk(ref_clk), .switch_on(switch_on), .pk_dly(8'h0a),
    .load_lvl(load_lvl), .sense_raw(sense_raw)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Order: fb_low, fb_rel_low, iout_over, vcc_stop, vcc_start
  task automatic drive(input logic [4:0] v);
    @(posedge ref_clk);
    load_lvl <= {v[4:3], 1'b0, v[2:0]};
  endtask

  task automatic step();
    @(negedge ref_clk);
    if (switch_on === 1'b1 && prev_sw !== 1'b1) strokes++;
    prev_sw = switch_on;
    waited++;
  endtask

  task automatic wait_mode(input fmc_mode_t m, input int lim);
    strokes = 0;
    waited = 0;
    prev_sw = switch_on;
    while (mode !== m && waited < lim) step();
    chk("mode", 16'(m), 16'(mode));
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    strokes = 0;
    waited = 0;
    prev_sw = switch_on;
    while (s !== v && waited < lim) step();
    chk("level", 16'(v), 16'(s));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_start();
    repeat (20) @(negedge ref_clk);
    chk("gate idle", 16'h0000, 16'(switch_on));
    drive(5'b00001);
    wait_mode(MODE_VOLTAGE_BURST, 5);
    chk("source off", 16'h0000, 16'(startup_src_on));
    $display("test start done");
  endtask

  task automatic t_burst();
    int n1;
    wait_lvl(switch_on, 1'b1, BP + MINP);
    chk("burst peak", 16'h0078, 16'(peak_target));
    wait_lvl(energy_save, 1'b1, 1000);
    wait_lvl(energy_save, 1'b0, BP + 10);
    chk("save strokes", 16'h0001, 16'(strokes));
    chk("burst opens", 16'h0001, 16'(switch_on));
    wait_lvl(energy_save, 1'b1, 1000);
    n1 = waited;
    wait_lvl(energy_save, 1'b0, BP + 10);
    chk("burst gap", 16'(BP), 16'(n1 + waited));
    chk("burst count", 16'h0001, 16'(burst_strokes));
    $display("test burst done");
  endtask

  task automatic t_fill();
    drive(5'b10001);
    wait_mode(MODE_VOLTAGE_PEAK_CURRENT, 3 * BP);
    chk("extra strokes", 16'h0001, 16'(strokes > 1));
    chk("entry peak", 16'h0078, 16'(peak_target));
    chk("entry period", 16'(MINP), period_len);
    $display("test fill done");
  endtask

  task automatic t_release();
    drive(5'b00001);
    wait_mode(MODE_VOLTAGE_BURST, 3 * MINP);
    drive(5'b11001);
    wait_mode(MODE_VOLTAGE_PEAK_CURRENT, 5);
    $display("test release done");
  endtask

  task automatic t_climb();
    drive(5'b10001);
    wait_mode(MODE_VOLTAGE_FREQUENCY, 95 * MINP);
    chk("peak max", 16'h0235, 16'(peak_target));
    chk("rate fixed", 16'(MINP), period_len);
    wait_mode(MODE_CURRENT_FREQUENCY, 10 * MINP);
    chk("rate ceiling", 16'(MAXP), period_len);
    chk("peak held", 16'h0235, 16'(peak_target));
    $display("test climb done");
  endtask

  task automatic t_current();
    drive(5'b10101);
    wait_mode(MODE_CURRENT_PEAK_CURRENT, 10 * MINP);
    chk("rate floor", 16'(MINP), period_len);
    chk("peak entry", 16'h0235, 16'(peak_target));
    repeat (3 * MINP) @(negedge ref_clk);
    chk("peak lowered", 16'h0001, 16'(peak_target < 10'h235));
    chk("rate kept", 16'(MINP), period_len);
    $display("test current done");
  endtask

  task automatic t_hiccup();
    drive(5'b00010);
    wait_mode(MODE_STARTUP, 5);
    chk("gate stop", 16'h0000, 16'(switch_on));
    chk("source on", 16'h0001, 16'(startup_src_on));
    repeat (20) @(negedge ref_clk);
    chk("stays off", 16'h0000, 16'(switch_on));
    drive(5'b00001);
    wait_mode(MODE_VOLTAGE_BURST, 5);
    $display("test hiccup done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    chk("reset peak", 16'h0078, 16'(peak_target));
    chk("reset period", 16'(MINP), period_len);
    chk("reset flags", 16'h0008,
        {10'h000, switch_on, energy_save, startup_src_on, mode});
    chk("reset count", 16'h0000, 16'(burst_strokes));
    @(posedge ref_clk);
    rst <= 1'b0;
    t_start();
    t_burst();
    t_fill();
    t_release();
    t_climb();
    t_current();
    t_hiccup();
    end_of_test();
  end

  // Whole run needs about 75k cycles
  initial begin
    repeat (100_000) @(posedge ref_clk);
    error_cnt++;
    $display("unexpected watchdog: expected finish seen hang");
    end_of_test();
  end
endmodule // fmc_top_bench
